// File: core/foc_pkg.sv
// Constants of the flow output conditioning block.
// Assumes a 10 MHz clock and a strobe register port.
package foc_pkg;
   // ****************
   // Clock and timing
   // ****************
   localparam int unsigned CLK_HZ = 10_000_000;
   // Filter tick every 1 ms
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   // Slug time in tenths of a second, 100 ticks each
   localparam int unsigned SLUG_UNIT_MS = 100;
   localparam logic [9:0] SLUG_TIME_MIN = 10'h001;
   localparam logic [9:0] SLUG_TIME_MAX = 10'h258;
   localparam logic [9:0] SLUG_TIME_RST = 10'h00A;
   // Calibration run length in ticks
   localparam int unsigned CAL_TICKS = 100;

   // ****************
   // Register offsets (index = parameter number)
   // ****************
   localparam logic [7:0] REG_SLUG_TIME = 8'h24;  // 36
   localparam logic [7:0] REG_SLUG_LOW = 8'h25;   // 37
   localparam logic [7:0] REG_SLUG_HIGH = 8'h26;  // 38
   localparam logic [7:0] REG_FLOW_DIR = 8'h27;   // 39
   localparam logic [7:0] REG_TEMP_DAMP = 8'h3D;  // 61
   localparam logic [7:0] REG_FLOW_DAMP = 8'h3E;  // 62
   localparam logic [7:0] REG_DENS_DAMP = 8'h3F;  // 63
   localparam logic [7:0] REG_CORE_STATUS = 8'h47; // 71
   localparam logic [7:0] REG_CAL_METHOD = 8'h48; // 72
   localparam logic [7:0] REG_IRQ_STATUS = 8'h80;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h81;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h82;

   // ****************
   // Fields and limits
   // ****************
   // Density in signed milli g/cc, 16 bits
   localparam logic signed [15:0] DENS_LIMIT_MIN = 16'shFF9C; // -0.1
   localparam logic signed [15:0] DENS_LIMIT_MAX = 16'sh1388; // 5.0
   localparam logic signed [15:0] SLUG_LOW_RST = 16'h0000;
   localparam logic signed [15:0] SLUG_HIGH_RST = 16'h1388;
   localparam logic [3:0] FLOW_DAMP_MAX = 4'hC;
   localparam logic [3:0] DENS_DAMP_MAX = 4'hA;
   localparam logic [3:0] TEMP_DAMP_MAX = 4'h8;
   // Interrupt bits
   localparam int unsigned IRQ_SLUG_ON = 0;
   localparam int unsigned IRQ_SLUG_TMO = 1;
   localparam int unsigned IRQ_CAL_DONE = 2;
   localparam int unsigned IRQ_BAD_WR = 3;
   localparam int unsigned IRQ_W = 4;
   // Core status codes
   localparam logic [1:0] CORE_IDLE = 2'h0;
   localparam logic [1:0] CORE_BUSY = 2'h1;
   localparam logic [1:0] CORE_CAL_OK = 2'h2;
   localparam logic [1:0] CORE_CAL_FAIL = 2'h3;

   typedef enum logic [2:0] {
      FOC_CAL_ZERO, FOC_CAL_CHAR, FOC_CAL_DENS_LO, FOC_CAL_DENS_HI,
      FOC_CAL_DENS_FLOW, FOC_CAL_TEMP_LO, FOC_CAL_TEMP_HI
   } foc_cal_method_e;

   // Damping time (ms) to shift k with 2^-k approx tick/tau
   function automatic logic [4:0] foc_shift_of_ms(input int unsigned ms);
      int unsigned k;
      k = 0;
      while (k < 20 && (TICK_US / 1000) * (1 << k) < ms) k = k + 1;
      return 5'(k);
   endfunction : foc_shift_of_ms
endpackage : foc_pkg

// File: core/foc_top.sv
// Flow output conditioning: direction sign, first-order damping on flow,
// density and temperature, slug hold and zeroing, calibration sequencing.
// Assumes synchronous 10 MHz inputs and a one-cycle strobe register port.
// What this block does
// - Output sign is fluid direction XOR configured direction
// - Direction at index 39, 0 forward, 1 reverse, reset forward
// - Damping is first-order; step reaches 63% in set time
// - Flow damping code 62 decodes 0..12 to 0..480 s
// - Density damping code 63 decodes 0..10 to 0.3..480 s
// - Temperature damping code 61 decodes 0..8 to 0..120 s
// - Slug flagged when density below low or above high limit
// - During slug the last good flow is held; resumes afterward
// - Slug timer 0.1..60 s; on expiry flow goes to zero
// - Writing the method selector starts that calibration; a write while one is running starts nothing
// - Selector offers seven methods, zero through high temperature
// - Characterization accepts factors, runs no sequence
// - Finished calibration posts success or failure in status 71
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module foc_top
#(
   parameter int unsigned DATA_W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Raw process variables, new sample each cycle
   input wire logic signed [DATA_W-1:0] flow_in,
   input wire logic fluid_reverse,
   input wire logic signed [15:0] dens_in,
   input wire logic signed [DATA_W-1:0] temp_in,
   // Calibration result from the measurement core
   input wire logic cal_fail,
   // Conditioned outputs
   output logic signed [DATA_W-1:0] flow_out,
   output logic signed [15:0] dens_out,
   output logic signed [DATA_W-1:0] temp_out,
   output logic slug_active,
   output logic cal_busy,
   output logic irq
);
   import foc_pkg::*;

   // ****************
   // Damping decode
   // ****************
   // Shift 31 marks pass-through (zero seconds)
   localparam logic [4:0] SHIFT_NONE = 5'h1F;
   localparam int unsigned TICKS_PER_SLUG_UNIT = SLUG_UNIT_MS * 1000 / TICK_US;

   function automatic logic [4:0] flow_shift(input logic [3:0] c);
      case (c)
         4'h0: return SHIFT_NONE;
         4'h1: return foc_shift_of_ms(100);
         4'h2: return foc_shift_of_ms(300);
         4'h3: return foc_shift_of_ms(800);
         4'h4: return foc_shift_of_ms(1700);
         4'h5: return foc_shift_of_ms(3500);
         4'h6: return foc_shift_of_ms(7000);
         4'h7: return foc_shift_of_ms(15000);
         4'h8: return foc_shift_of_ms(30000);
         4'h9: return foc_shift_of_ms(60000);
         4'hA: return foc_shift_of_ms(120000);
         4'hB: return foc_shift_of_ms(240000);
         default: return foc_shift_of_ms(480000);
      endcase
   endfunction : flow_shift

   function automatic logic [4:0] dens_shift(input logic [3:0] c);
      // Density code is the flow code shifted by two: no zero setting
      return flow_shift(c + 4'h2);
   endfunction : dens_shift

   function automatic logic [4:0] temp_shift(input logic [3:0] c);
      case (c)
         4'h0: return SHIFT_NONE;
         4'h1: return foc_shift_of_ms(300);
         4'h2: return foc_shift_of_ms(800);
         default: return flow_shift(c + 4'h2);
      endcase
   endfunction : temp_shift

   // ****************
   // Configuration registers
   // ****************
   logic flow_dir_reg, flow_dir_next;
   logic [3:0] flow_damp_reg, flow_damp_next;
   logic [3:0] dens_damp_reg, dens_damp_next;
   logic [3:0] temp_damp_reg, temp_damp_next;
   logic signed [15:0] slug_low_reg, slug_low_next;
   logic signed [15:0] slug_high_reg, slug_high_next;
   logic [9:0] slug_time_reg, slug_time_next;
   logic [2:0] cal_method_reg, cal_method_next;
   logic [IRQ_W-1:0] irq_en_reg, irq_en_next;
   logic bad_wr;
   logic cal_start;
   logic signed [15:0] wsig;

   assign wsig = reg_wdata;

   // Writes with range checks; illegal values keep the old setting
   always_comb begin
      flow_dir_next = flow_dir_reg;
      flow_damp_next = flow_damp_reg;
      dens_damp_next = dens_damp_reg;
      temp_damp_next = temp_damp_reg;
      slug_low_next = slug_low_reg;
      slug_high_next = slug_high_reg;
      slug_time_next = slug_time_reg;
      cal_method_next = cal_method_reg;
      irq_en_next = irq_en_reg;
      bad_wr = 1'b0;
      cal_start = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            REG_FLOW_DIR: if (reg_wdata[15:1] == 15'h0000) flow_dir_next = reg_wdata[0];
               else bad_wr = 1'b1;
            REG_FLOW_DAMP: if (reg_wdata <= 16'(FLOW_DAMP_MAX)) flow_damp_next = reg_wdata[3:0];
               else bad_wr = 1'b1;
            REG_DENS_DAMP: if (reg_wdata <= 16'(DENS_DAMP_MAX)) dens_damp_next = reg_wdata[3:0];
               else bad_wr = 1'b1;
            REG_TEMP_DAMP: if (reg_wdata <= 16'(TEMP_DAMP_MAX)) temp_damp_next = reg_wdata[3:0];
               else bad_wr = 1'b1;
            REG_SLUG_LOW: if (wsig >= DENS_LIMIT_MIN && wsig <= DENS_LIMIT_MAX)
               slug_low_next = wsig;
               else bad_wr = 1'b1;
            REG_SLUG_HIGH: if (wsig >= DENS_LIMIT_MIN && wsig <= DENS_LIMIT_MAX)
               slug_high_next = wsig;
               else bad_wr = 1'b1;
            REG_SLUG_TIME: if (reg_wdata >= 16'(SLUG_TIME_MIN) && reg_wdata <= 16'(SLUG_TIME_MAX))
               slug_time_next = reg_wdata[9:0];
               else bad_wr = 1'b1;
            REG_CAL_METHOD: if (reg_wdata <= 16'(FOC_CAL_TEMP_HI)) begin
               cal_method_next = reg_wdata[2:0];
               cal_start = 1'b1;
            end else bad_wr = 1'b1;
            REG_IRQ_ENABLE: irq_en_next = reg_wdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Register the configuration
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flow_dir_reg <= 1'b0;
         flow_damp_reg <= 4'h0;
         dens_damp_reg <= 4'h0;
         temp_damp_reg <= 4'h0;
         slug_low_reg <= SLUG_LOW_RST;
         slug_high_reg <= SLUG_HIGH_RST;
         slug_time_reg <= SLUG_TIME_RST;
         cal_method_reg <= 3'h0;
         irq_en_reg <= '0;
      end else begin
         flow_dir_reg <= flow_dir_next;
         flow_damp_reg <= flow_damp_next;
         dens_damp_reg <= dens_damp_next;
         temp_damp_reg <= temp_damp_next;
         slug_low_reg <= slug_low_next;
         slug_high_reg <= slug_high_next;
         slug_time_reg <= slug_time_next;
         cal_method_reg <= cal_method_next;
         irq_en_reg <= irq_en_next;
      end
   end

   // ****************
   // Tick divider and filters
   // ****************
   logic [15:0] tick_cnt_reg, tick_cnt_next;
   logic tick;
   // Filters step once per tick so long time constants fit in a shift
   always_comb begin
      tick = (tick_cnt_reg == 16'(TICK_CYC - 1));
      tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) tick_cnt_reg <= 16'h0000;
      else tick_cnt_reg <= tick_cnt_next;
   end

   logic signed [DATA_W-1:0] flow_signed;
   logic signed [DATA_W-1:0] flow_filt, temp_filt;
   logic signed [15:0] dens_filt;
   // Sense flips when fluid direction and setting differ
   assign flow_signed = (fluid_reverse ^ flow_dir_reg) ? -flow_in : flow_in;

   foc_damp #(.W(DATA_W)) u_flow_damp (.clk(clk), .sys_rst(sys_rst), .tick(tick),
      .shift(flow_shift(flow_damp_reg)), .din(flow_signed), .dout(flow_filt));
   foc_damp #(.W(16)) u_dens_damp (.clk(clk), .sys_rst(sys_rst), .tick(tick),
      .shift(dens_shift(dens_damp_reg)), .din(dens_in), .dout(dens_filt));
   foc_damp #(.W(DATA_W)) u_temp_damp (.clk(clk), .sys_rst(sys_rst), .tick(tick),
      .shift(temp_shift(temp_damp_reg)), .din(temp_in), .dout(temp_filt));

   // ****************
   // Slug hold, timer, outputs, calibration, interrupts
   // ****************
   typedef enum {FOC_ST_IDLE, FOC_ST_RUN} foc_cal_st_e;
   foc_cal_st_e cal_st_reg, cal_st_next;
   logic [6:0] cal_cnt_reg, cal_cnt_next;
   logic [1:0] core_reg, core_next;
   logic slug_now;
   logic [15:0] slug_cnt_reg, slug_cnt_next;
   logic signed [DATA_W-1:0] flow_out_next, good_reg, good_next;
   logic slug_tmo;
   logic [IRQ_W-1:0] irq_st_reg, irq_st_next, irq_ev;
   logic [15:0] rdata_next;

   always_comb begin
      slug_now = (dens_in < slug_low_reg) || (dens_in > slug_high_reg);
      slug_tmo = slug_now && (slug_cnt_reg >= 16'(slug_time_reg * TICKS_PER_SLUG_UNIT));
      slug_cnt_next = !slug_now ? 16'h0000
         : (tick && !slug_tmo) ? slug_cnt_reg + 16'h0001 : slug_cnt_reg;
      good_next = slug_now ? good_reg : flow_filt;
      if (!slug_now) flow_out_next = flow_filt;
      else if (slug_tmo) flow_out_next = '0;
      else flow_out_next = good_reg;
      // Calibration sequencer; characterization only accepts factors
      cal_st_next = cal_st_reg;
      cal_cnt_next = cal_cnt_reg;
      core_next = core_reg;
      irq_ev = '0;
      case (cal_st_reg)
         FOC_ST_IDLE: if (cal_start) begin
            if (cal_method_next == 3'(FOC_CAL_CHAR)) begin
               core_next = CORE_CAL_OK;
               irq_ev[IRQ_CAL_DONE] = 1'b1;
            end else begin
               cal_st_next = FOC_ST_RUN;
               cal_cnt_next = 7'h00;
               core_next = CORE_BUSY;
            end
         end
         FOC_ST_RUN: if (tick) begin
            if (cal_cnt_reg == 7'(CAL_TICKS - 1)) begin
               cal_st_next = FOC_ST_IDLE;
               core_next = cal_fail ? CORE_CAL_FAIL : CORE_CAL_OK;
               irq_ev[IRQ_CAL_DONE] = 1'b1;
            end else cal_cnt_next = cal_cnt_reg + 7'h01;
         end
         default: cal_st_next = FOC_ST_IDLE;
      endcase
      irq_ev[IRQ_SLUG_ON] = slug_now && !slug_active;
      irq_ev[IRQ_SLUG_TMO] = slug_tmo && flow_out != '0 && flow_out_next == '0;
      irq_ev[IRQ_BAD_WR] = bad_wr;
      // Set wins over a clear in the same cycle
      irq_st_next = irq_st_reg;
      if (reg_wr && reg_addr == REG_IRQ_CLEAR) irq_st_next = irq_st_reg & ~reg_wdata[IRQ_W-1:0];
      irq_st_next = irq_st_next | irq_ev;
      case (reg_addr)
         REG_FLOW_DIR: rdata_next = {15'h0000, flow_dir_reg};
         REG_FLOW_DAMP: rdata_next = {12'h000, flow_damp_reg};
         REG_DENS_DAMP: rdata_next = {12'h000, dens_damp_reg};
         REG_TEMP_DAMP: rdata_next = {12'h000, temp_damp_reg};
         REG_SLUG_LOW: rdata_next = slug_low_reg;
         REG_SLUG_HIGH: rdata_next = slug_high_reg;
         REG_SLUG_TIME: rdata_next = {6'h00, slug_time_reg};
         REG_CAL_METHOD: rdata_next = {13'h0000, cal_method_reg};
         REG_CORE_STATUS: rdata_next = {14'h0000, core_reg};
         REG_IRQ_STATUS: rdata_next = 16'(irq_st_reg);
         REG_IRQ_ENABLE: rdata_next = 16'(irq_en_reg);
         default: rdata_next = 16'h0000;
      endcase
      if (!reg_rd) rdata_next = 16'h0000;
   end

   // Register outputs and state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         slug_cnt_reg <= 16'h0000;
         good_reg <= '0;
         flow_out <= '0;
         dens_out <= '0;
         temp_out <= '0;
         slug_active <= 1'b0;
         cal_st_reg <= FOC_ST_IDLE;
         cal_cnt_reg <= 7'h00;
         core_reg <= CORE_IDLE;
         cal_busy <= 1'b0;
         irq_st_reg <= '0;
         irq <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         slug_cnt_reg <= slug_cnt_next;
         good_reg <= good_next;
         flow_out <= flow_out_next;
         dens_out <= dens_filt;
         temp_out <= temp_filt;
         slug_active <= slug_now;
         cal_st_reg <= cal_st_next;
         cal_cnt_reg <= cal_cnt_next;
         core_reg <= core_next;
         cal_busy <= (cal_st_next == FOC_ST_RUN);
         irq_st_reg <= irq_st_next;
         irq <= |(irq_st_next & irq_en_next);
         reg_rdata <= rdata_next;
      end
   end
endmodule : foc_top

// ****************
// First-order damping stage
// ****************
module foc_damp #(
   parameter int unsigned W = 24
) (
   // Clock, reset, step enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   // Shift and samples
   input wire logic [4:0] shift,
   input wire logic signed [W-1:0] din,
   output logic signed [W-1:0] dout
);
   // Extra fraction bits keep small steps from stalling
   logic signed [W+23:0] acc_reg, acc_next;
   logic signed [W+23:0] din_x;
   always_comb begin
      din_x = {din, 24'h000000};
      if (shift == 5'h1F) acc_next = din_x;
      else if (tick) acc_next = acc_reg + ((din_x - acc_reg) >>> shift);
      else acc_next = acc_reg;
      dout = (shift == 5'h1F) ? din : acc_reg[W+23:24];
   end
   always_ff @(posedge clk) begin
      if (sys_rst) acc_reg <= '0;
      else acc_reg <= acc_next;
   end
endmodule : foc_damp

// File: bench/foc_check_props.sv
// Checker for the conditioning block: shadow settings, output causes.
// Assumes it is bound to foc_top and sees only its ports.
`timescale 1ns/100ps
module foc_check
   import foc_pkg::*;
#(
   parameter int unsigned DATA_W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Process values in and out
   input wire logic signed [DATA_W-1:0] flow_in,
   input wire logic fluid_reverse,
   input wire logic signed [15:0] dens_in,
   input wire logic signed [DATA_W-1:0] temp_in,
   input wire logic cal_fail,
   input wire logic signed [DATA_W-1:0] flow_out,
   input wire logic signed [15:0] dens_out,
   input wire logic signed [DATA_W-1:0] temp_out,
   input wire logic slug_active,
   input wire logic cal_busy,
   input wire logic irq
);
   logic dir_reg, fpass_reg, tpass_reg, sbad_reg, sout_reg, dens_ok, lim_ok, st_ok;
   logic [3:0] fd_reg, td_reg;
   logic [9:0] st_reg;
   logic signed [15:0] lo_reg, hi_reg, wds;
   logic signed [DATA_W-1:0] eflow_reg, etemp_reg;
   logic [31:0] scnt_reg;
   assign wds = reg_wdata;
   assign lim_ok = (wds >= DENS_LIMIT_MIN) && (wds <= DENS_LIMIT_MAX);
   assign st_ok = (reg_wdata >= 16'(SLUG_TIME_MIN)) && (reg_wdata <= 16'(SLUG_TIME_MAX));
   assign dens_ok = (dens_in >= lo_reg) && (dens_in <= hi_reg);
   // Shadow settings; out-of-range writes dropped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dir_reg <= 1'b0;
         fd_reg <= 4'h0;
         td_reg <= 4'h0;
         st_reg <= SLUG_TIME_RST;
         lo_reg <= SLUG_LOW_RST;
         hi_reg <= SLUG_HIGH_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_FLOW_DIR && reg_wdata[15:1] == 15'h0000) dir_reg <= reg_wdata[0];
         if (reg_addr == REG_FLOW_DAMP && reg_wdata <= 16'(FLOW_DAMP_MAX)) fd_reg <= reg_wdata[3:0];
         if (reg_addr == REG_TEMP_DAMP && reg_wdata <= 16'(TEMP_DAMP_MAX)) td_reg <= reg_wdata[3:0];
         if (reg_addr == REG_SLUG_TIME && st_ok) st_reg <= reg_wdata[9:0];
         if (reg_addr == REG_SLUG_LOW && lim_ok) lo_reg <= wds;
         if (reg_addr == REG_SLUG_HIGH && lim_ok) hi_reg <= wds;
      end
   end
   // Expected values one cycle on, armed when nothing interferes
   always_ff @(posedge clk) begin
      fpass_reg <= !sys_rst && !reg_wr && fd_reg == 4'h0 && dens_ok && !slug_active;
      eflow_reg <= (fluid_reverse ^ dir_reg) ? -flow_in : flow_in;
      tpass_reg <= !sys_rst && !reg_wr && td_reg == 4'h0;
      etemp_reg <= temp_in;
      sbad_reg <= sys_rst || reg_wr;
      sout_reg <= !dens_ok;
      scnt_reg <= (slug_active && !sys_rst) ? scnt_reg + 32'h1 : 32'h0;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_slug_run;
      slug_active ##1 slug_active;
   endsequence
   chk_flow_sign: assert property (fpass_reg |-> flow_out == eflow_reg)
      else $error("flow sign wrong");
   chk_temp_pass: assert property (tpass_reg |-> temp_out == etemp_reg)
      else $error("temp not passed");
   chk_slug_flag: assert property (!sbad_reg |-> slug_active == sout_reg)
      else $error("slug flag wrong");
   chk_slug_hold: assert property ((s_slug_run ##0 (flow_out != '0 && !$past(reg_wr)))
      |-> $stable(flow_out)) else $error("flow moved during slug");
   // The zero may come two ticks late
   chk_slug_zero: assert property ((slug_active && scnt_reg > 32'(st_reg) * 32'd1000000 + 32'd20000)
      |-> flow_out == '0) else $error("flow not zeroed");
   chk_dir_read: assert property ($past(reg_rd) && $past(reg_addr) == REG_FLOW_DIR
      |-> reg_rdata == {15'h0, $past(dir_reg)}) else $error("direction readback wrong");
   chk_damp_read: assert property ($past(reg_rd) && $past(reg_addr) == REG_FLOW_DAMP
      |-> reg_rdata == {12'h0, $past(fd_reg)}) else $error("damping readback wrong");
   chk_cal_start: assert property ((reg_wr && reg_addr == REG_CAL_METHOD && reg_wdata <= 16'h0006
      && reg_wdata != 16'h0001) |=> cal_busy) else $error("cal not started");
endmodule : foc_check

bind foc_top foc_check #(.DATA_W(DATA_W)) u_chk (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .flow_in(flow_in), .fluid_reverse(fluid_reverse),
   .dens_in(dens_in), .temp_in(temp_in), .cal_fail(cal_fail), .flow_out(flow_out),
   .dens_out(dens_out), .temp_out(temp_out), .slug_active(slug_active),
   .cal_busy(cal_busy), .irq(irq));

// File: bench/foc_host.sv
// Host model: reads and writes parameters over the register port.
// Assumes one clock; the bench calls its tasks hierarchically.
`timescale 1ns/100ps
module foc_host (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   import foc_pkg::*;
   // Idle bus from time zero
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
   // Each variable gets its own code, as the caller asks
   task automatic set_damp(input logic [7:0] a, input logic [3:0] code);
      wr(a, {12'h000, code});
   endtask : set_damp
   // Limits always go out in milli g/cc
   task automatic set_limits(input logic [15:0] lo, input logic [15:0] hi);
      wr(REG_SLUG_LOW, lo);
      wr(REG_SLUG_HIGH, hi);
   endtask : set_limits
   // Zeroing comes before any trusted measurement
   task automatic zero_cal();
      wr(REG_CAL_METHOD, 16'h0000);
   endtask : zero_cal
endmodule : foc_host

// File: bench/testbench.sv
// Self-checking bench for the conditioning block.
// Assumes the package, host and checker compile first.
`timescale 1ns/100ps
module testbench;
   import foc_pkg::*;
   // ****************
   // Signals and design
   // ****************
   typedef struct packed {logic dir; logic rev; logic [23:0] flow; logic [23:0] exp;} foc_row_s;
   foc_row_s rows [6] = '{'{1'b0, 1'b0, 24'h001234, 24'h001234},
      '{1'b0, 1'b1, 24'h001234, 24'hFFEDCC}, '{1'b1, 1'b0, 24'h001234, 24'hFFEDCC},
      '{1'b1, 1'b1, 24'h001234, 24'h001234}, '{1'b0, 1'b0, 24'hFFF000, 24'hFFF000},
      '{1'b1, 1'b0, 24'hFFF000, 24'h001000}};
   logic [7:0] ra [9] = '{REG_FLOW_DIR, REG_FLOW_DAMP, REG_DENS_DAMP, REG_TEMP_DAMP,
      REG_SLUG_TIME, REG_SLUG_LOW, REG_SLUG_HIGH, REG_CORE_STATUS, 8'h10};
   logic [15:0] re [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000A, 16'h0000,
      16'h1388, 16'h0000, 16'h0000};
   logic [7:0] da [3] = '{REG_FLOW_DAMP, REG_DENS_DAMP, REG_TEMP_DAMP};
   logic [3:0] dm [3] = '{4'hC, 4'hA, 4'h8};
   logic clk, sys_rst, reg_wr, reg_rd, fluid_reverse, cal_fail, slug_active, cal_busy, irq;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv, dens_in, dens_out;
   logic [23:0] flow_in, temp_in, flow_out, temp_out;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   foc_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   foc_top #(.DATA_W(24)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .flow_in(flow_in), .fluid_reverse(fluid_reverse), .dens_in(dens_in), .temp_in(temp_in),
      .cal_fail(cal_fail), .flow_out(flow_out), .dens_out(dens_out), .temp_out(temp_out),
      .slug_active(slug_active), .cal_busy(cal_busy), .irq(irq));
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Hang guard above the 26000 cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_mismatch++;
         results();
      end
   end
   // ****************
   // Helpers
   // ****************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
   endtask : do_reset
   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // ****************
   // Main sequence
   // ****************
   initial begin
      sys_rst = 1'b1;
      flow_in = 24'h000000;
      temp_in = 24'h000000;
      dens_in = 16'h03E8;
      fluid_reverse = 1'b0;
      cal_fail = 1'b0;
      do_reset();
      // Direction table at zero damping
      foreach (rows[i]) begin
         u_host.wr(REG_FLOW_DIR, {15'h0000, rows[i].dir});
         @(posedge clk);
         fluid_reverse <= rows[i].rev;
         flow_in <= rows[i].flow;
         temp_in <= rows[i].flow;
         repeat (3) @(posedge clk);
         check("flow_out", 32'(rows[i].exp), 32'(flow_out));
         check("temp_out", 32'(rows[i].flow), 32'(temp_out));
      end
      // Reset values, mid-run, plus an unmapped index
      do_reset();
      foreach (ra[i]) begin
         u_host.rd(ra[i], rv);
         check("reset value", 32'(re[i]), 32'(rv));
      end
      // Highest code kept, one above it refused
      for (int i = 0; i < 3; i++) begin
         u_host.set_damp(da[i], dm[i]);
         u_host.set_damp(da[i], dm[i] + 4'h1);
         u_host.rd(da[i], rv);
         check("damping code", 32'(dm[i]), 32'(rv));
      end
      u_host.rd(REG_IRQ_STATUS, rv);
      check("reject flag", 32'h1, 32'(rv[IRQ_BAD_WR]));
      u_host.wr(REG_IRQ_ENABLE, 16'h0008);
      repeat (2) @(posedge clk);
      check("irq raised", 32'h1, 32'(irq));
      u_host.wr(REG_IRQ_CLEAR, 16'h0008);
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h0, 32'(irq));
      // Step into 0.1 s flow damping: two or three ticks
      flow_in <= 24'h000000;
      u_host.set_damp(REG_FLOW_DAMP, 4'h0);
      u_host.set_damp(REG_FLOW_DAMP, 4'h1);
      flow_in <= 24'h100000;
      repeat (25000) @(posedge clk);
      check("damped rise", 32'h1, 32'(flow_out > 24'h001000 && flow_out < 24'h010000));
      u_host.set_damp(REG_FLOW_DAMP, 4'h0);
      // Slug limits, hold and release
      u_host.set_limits(16'h01F4, 16'h05DC);
      u_host.wr(REG_SLUG_HIGH, 16'h1389);
      u_host.rd(REG_SLUG_HIGH, rv);
      check("slug high", 32'h05DC, 32'(rv));
      flow_in <= 24'h000100;
      repeat (4) @(posedge clk);
      dens_in <= 16'h07D0;
      repeat (3) @(posedge clk);
      flow_in <= 24'h000200;
      check("slug on", 32'h1, 32'(slug_active));
      check("dens damped", 32'h1, 32'(dens_out != 16'h07D0));
      repeat (3) @(posedge clk);
      check("held flow", 32'h000100, 32'(flow_out));
      dens_in <= 16'h03E8;
      repeat (3) @(posedge clk);
      check("slug off", 32'h0, 32'(slug_active));
      check("live flow", 32'h000200, 32'(flow_out));
      dens_in <= 16'h0190;
      repeat (3) @(posedge clk);
      check("slug low", 32'h1, 32'(slug_active));
      dens_in <= 16'h03E8;
      u_host.rd(REG_IRQ_STATUS, rv);
      check("slug event", 32'h1, 32'(rv[IRQ_SLUG_ON]));
      // Slug time bounds
      u_host.wr(REG_SLUG_TIME, 16'h0000);
      u_host.wr(REG_SLUG_TIME, 16'h0259);
      u_host.rd(REG_SLUG_TIME, rv);
      check("slug time kept", 32'h000A, 32'(rv));
      u_host.wr(REG_SLUG_TIME, 16'h0258);
      u_host.rd(REG_SLUG_TIME, rv);
      check("slug time max", 32'h0258, 32'(rv));
      // Every method once; characterization finishes at once
      for (int m = 0; m < 7; m++) begin
         do_reset();
         if (m == 0) u_host.zero_cal();
         else u_host.wr(REG_CAL_METHOD, 16'(m));
         u_host.rd(REG_CORE_STATUS, rv);
         check("cal status", (m == 1) ? 32'(CORE_CAL_OK) : 32'(CORE_BUSY), 32'(rv));
         check("cal busy", (m == 1) ? 32'h0 : 32'h1, 32'(cal_busy));
      end
      results();
   end
endmodule : testbench
